// file: pkg/led_pkg.sv
// constants for the port status led driver: register map, fields, reset values, timing
// assumes a 25 MHz core clock and an apb register bus with 32-bit data
package led_pkg;

  // register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;

  // control register fields
  localparam int CTRL_DUAL_STORED_BIT = 0;
  localparam int CTRL_LED_ENABLE_BIT = 1;
  localparam int CTRL_DUPLEX_ONLY_BIT = 2;
  localparam int CTRL_COL_SPLIT_BIT = 3;
  localparam int CTRL_WIDTH = 4;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // status register fields
  localparam int STATUS_PHASE_LSB = 0;
  localparam int STATUS_DUAL_BIT = 3;
  localparam int STATUS_HOLD_BIT = 4;
  localparam int STATUS_STRAP_LSB = 5;

  // timing: clock, prescaler tick, self-test phases, blink half periods
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_US = 5000;
  localparam int TICK_CYCLES = (TICK_US * 1000) / CLK_PERIOD_NS;
  localparam int ON_TEST_MS = 1280;
  localparam int OFF_TEST_MS = 480;
  localparam int DUAL_ON_TEST_MS = 2560;
  localparam int BLINK_SLOW_HZ = 10;
  localparam int BLINK_FAST_HZ = 20;
  localparam int ON_TEST_TICKS = (ON_TEST_MS * 1000) / TICK_US;
  localparam int OFF_TEST_TICKS = (OFF_TEST_MS * 1000) / TICK_US;
  localparam int DUAL_ON_TEST_TICKS = (DUAL_ON_TEST_MS * 1000) / TICK_US;
  localparam int BLINK_SLOW_TICKS = 1000000 / (2 * BLINK_SLOW_HZ * TICK_US);
  localparam int BLINK_FAST_TICKS = 1000000 / (2 * BLINK_FAST_HZ * TICK_US);
  localparam int PHASE_TIMER_WIDTH = 10;

  typedef enum logic [2:0] {
    ST_STRAP = 3'b000,
    ST_WAIT = 3'b001,
    ST_ON_TEST = 3'b010,
    ST_YELLOW_TEST = 3'b011,
    ST_OFF_TEST = 3'b100,
    ST_NORMAL = 3'b101
  } phase_type;

endpackage

// file: verilog/led_prescaler.sv
// free-running prescaler: slow tick plus 50 percent duty blink squares
// assumes pclk at the package clock rate; ce low freezes it
`timescale 1ns/10ps
`default_nettype none
module led_prescaler #(
  parameter int TICK_CYCLES = led_pkg::TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  output logic tick,
  output logic blink_slow,
  output logic blink_fast
);

  logic [23:0] cyc_r, cyc_nxt;
  logic [3:0] slow_r, slow_nxt;
  logic [3:0] fast_r, fast_nxt;
  logic tick_r, tick_nxt;
  logic bslow_r, bslow_nxt;
  logic bfast_r, bfast_nxt;

  always_comb begin
    cyc_nxt = cyc_r + 24'h000001;
    tick_nxt = 1'b0;
    slow_nxt = slow_r;
    fast_nxt = fast_r;
    bslow_nxt = bslow_r;
    bfast_nxt = bfast_r;
    if (cyc_r == 24'(TICK_CYCLES - 1)) begin
      cyc_nxt = 24'h000000;
      tick_nxt = 1'b1;
      // blink squares toggle on whole ticks so both halves are equal
      if (slow_r == 4'(led_pkg::BLINK_SLOW_TICKS - 1)) begin
        slow_nxt = 4'h0;
        bslow_nxt = ~bslow_r;
      end else begin
        slow_nxt = slow_r + 4'h1;
      end
      if (fast_r == 4'(led_pkg::BLINK_FAST_TICKS - 1)) begin
        fast_nxt = 4'h0;
        bfast_nxt = ~bfast_r;
      end else begin
        fast_nxt = fast_r + 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_r <= 24'h000000;
      slow_r <= 4'h0;
      fast_r <= 4'h0;
      tick_r <= 1'b0;
      bslow_r <= 1'b0;
      bfast_r <= 1'b0;
    end else if (ce) begin
      cyc_r <= cyc_nxt;
      slow_r <= slow_nxt;
      fast_r <= fast_nxt;
      tick_r <= tick_nxt;
      bslow_r <= bslow_nxt;
      bfast_r <= bfast_nxt;
    end
  end

  assign tick = tick_r;
  assign blink_slow = bslow_r;
  assign blink_fast = bfast_r;

endmodule
`default_nettype wire

// file: verilog/port_led_display_driver.sv
// per-port status led driver: self-test after reset, then link, speed, duplex, collision
// assumes port status inputs synchronous to pclk and an apb master on the register side
//
// How it works
// - link/activity leds active low, no strap; driven low 1.28 s after reset
// - then link/activity and speed driven high 0.48 s, then normal display
// - link/activity low when linked idle, high when down, 10 Hz blink on traffic
// - speed led follows self-test; low only when linked at 100M
// - duplex/collision strap latched at reset; test shows inverse, then latched level
// - duplex/collision shows inverse when full duplex, latched when down, 10 Hz collision
// - duplex-only mode: inverse on full duplex, latched otherwise, no collision blink
// - collision split: pin 0 blinks 20 Hz on any 10M half-duplex collision
// - collision split: pin 1 blinks 20 Hz on any 100M half-duplex collision
// - dual colour test: green 1.28 s, yellow 1.28 s, then off
// - dual colour: off pair when down, steady green pair when idle at 100M
// - dual colour traffic blinks 10 Hz: green via (1,0) at 100M, yellow at 10M
// - dual colour keeps duplex/collision behaviour but its on-test lasts 2.56 s
// - stored colour select counts only with hold-test strap high, else strap value
// - hold-test strap high defers self-test until software sets led enable
`timescale 1ns/10ps
`default_nettype none
module port_led_display_driver #(
  parameter int NUM_PORTS = 5,
  parameter int TICK_CYCLES = led_pkg::TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic strap_input_pin,
  input wire logic hold_test_strap,
  input wire logic [NUM_PORTS-1:0] port_link,
  input wire logic [NUM_PORTS-1:0] port_speed_100,
  input wire logic [NUM_PORTS-1:0] port_full_duplex,
  input wire logic [NUM_PORTS-1:0] port_activity,
  input wire logic [NUM_PORTS-1:0] port_collision,
  output logic [NUM_PORTS-1:0] link_activity_led,
  output logic [NUM_PORTS-1:0] speed_led,
  input wire logic [NUM_PORTS-1:0] dupcol_in,
  output logic [NUM_PORTS-1:0] dupcol_out,
  output logic [NUM_PORTS-1:0] dupcol_oe
);

  logic tick;
  logic blink_slow;
  logic blink_fast;

  led_prescaler #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .tick(tick),
    .blink_slow(blink_slow),
    .blink_fast(blink_fast)
  );

  // register and strap state
  logic [led_pkg::CTRL_WIDTH-1:0] ctrl_r, ctrl_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [NUM_PORTS-1:0] strap_r, strap_nxt;
  logic dual_strap_r, dual_strap_nxt;
  logic hold_r, hold_nxt;

  // sequencer state
  led_pkg::phase_type phase_r, phase_nxt;
  logic [led_pkg::PHASE_TIMER_WIDTH-1:0] timer_r, timer_nxt;

  // led outputs
  logic [NUM_PORTS-1:0] lnk_r, lnk_nxt;
  logic [NUM_PORTS-1:0] spd_r, spd_nxt;
  logic [NUM_PORTS-1:0] dc_r, dc_nxt;
  logic [NUM_PORTS-1:0] dc_oe_r, dc_oe_nxt;

  logic dual_mode;
  logic led_enable;
  logic duplex_only;
  logic col_split;
  logic col_ten_flag;
  logic col_hundred_flag;
  logic [led_pkg::PHASE_TIMER_WIDTH-1:0] phase_len;

  assign led_enable = ctrl_r[led_pkg::CTRL_LED_ENABLE_BIT];
  assign duplex_only = ctrl_r[led_pkg::CTRL_DUPLEX_ONLY_BIT];
  assign col_split = ctrl_r[led_pkg::CTRL_COL_SPLIT_BIT];
  assign dual_mode = hold_r ? ctrl_r[led_pkg::CTRL_DUAL_STORED_BIT] : dual_strap_r;
  assign col_ten_flag = |(port_link & ~port_speed_100 & ~port_full_duplex & port_collision);
  assign col_hundred_flag = |(port_link & port_speed_100 & ~port_full_duplex & port_collision);

  function automatic logic is_reg(input logic [7:0] addr);
    is_reg = (addr == led_pkg::CTRL_OFFSET) || (addr == led_pkg::STATUS_OFFSET);
  endfunction

  // apb slave: pready raised in the first access cycle, so no wait states
  always_comb begin
    ctrl_nxt = ctrl_r;
    prdata_nxt = prdata_r;
    pready_nxt = psel && !penable;
    pslverr_nxt = psel && !penable && !is_reg(paddr);
    if (psel && !penable && !pwrite) begin
      prdata_nxt = 32'h00000000;
      if (paddr == led_pkg::CTRL_OFFSET) begin
        prdata_nxt[led_pkg::CTRL_WIDTH-1:0] = ctrl_r;
      end else if (paddr == led_pkg::STATUS_OFFSET) begin
        prdata_nxt[led_pkg::STATUS_PHASE_LSB +: 3] = phase_r;
        prdata_nxt[led_pkg::STATUS_DUAL_BIT] = dual_mode;
        prdata_nxt[led_pkg::STATUS_HOLD_BIT] = hold_r;
        prdata_nxt[led_pkg::STATUS_STRAP_LSB +: NUM_PORTS] = strap_r;
      end
    end
    if (psel && penable && pready_r && pwrite && paddr == led_pkg::CTRL_OFFSET) begin
      ctrl_nxt = pwdata[led_pkg::CTRL_WIDTH-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= led_pkg::CTRL_RESET;
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (ce) begin
      ctrl_r <= ctrl_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // sequencer: straps caught on the first enabled edge after reset release
  always_comb begin
    phase_nxt = phase_r;
    timer_nxt = timer_r;
    strap_nxt = strap_r;
    dual_strap_nxt = dual_strap_r;
    hold_nxt = hold_r;
    phase_len = led_pkg::PHASE_TIMER_WIDTH'(led_pkg::ON_TEST_TICKS);
    case (phase_r)
      led_pkg::ST_YELLOW_TEST: phase_len = led_pkg::PHASE_TIMER_WIDTH'(led_pkg::ON_TEST_TICKS);
      led_pkg::ST_OFF_TEST: phase_len = led_pkg::PHASE_TIMER_WIDTH'(led_pkg::OFF_TEST_TICKS);
      default: phase_len = led_pkg::PHASE_TIMER_WIDTH'(led_pkg::ON_TEST_TICKS);
    endcase
    case (phase_r)
      led_pkg::ST_STRAP: begin
        strap_nxt = dupcol_in;
        dual_strap_nxt = strap_input_pin;
        hold_nxt = hold_test_strap;
        phase_nxt = led_pkg::ST_WAIT;
      end
      led_pkg::ST_WAIT: begin
        if (!hold_r || led_enable) begin
          phase_nxt = led_pkg::ST_ON_TEST;
          timer_nxt = '0;
        end
      end
      led_pkg::ST_ON_TEST, led_pkg::ST_YELLOW_TEST, led_pkg::ST_OFF_TEST: begin
        // phases count whole prescaler ticks, so the on-test, entered between ticks, may run up to one tick short
        if (tick) begin
          timer_nxt = timer_r + 1'b1;
          if (timer_r == phase_len - 1'b1) begin
            timer_nxt = '0;
            if (phase_r == led_pkg::ST_ON_TEST && dual_mode) begin
              phase_nxt = led_pkg::ST_YELLOW_TEST;
            end else if (phase_r == led_pkg::ST_OFF_TEST) begin
              phase_nxt = led_pkg::ST_NORMAL;
            end else begin
              phase_nxt = led_pkg::ST_OFF_TEST;
            end
          end
        end
      end
      led_pkg::ST_NORMAL: phase_nxt = led_pkg::ST_NORMAL;
      default: phase_nxt = led_pkg::ST_STRAP;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= led_pkg::ST_STRAP;
      timer_r <= '0;
      strap_r <= '0;
      dual_strap_r <= 1'b0;
      hold_r <= 1'b0;
    end else if (ce) begin
      phase_r <= phase_nxt;
      timer_r <= timer_nxt;
      strap_r <= strap_nxt;
      dual_strap_r <= dual_strap_nxt;
      hold_r <= hold_nxt;
    end
  end

  // normal-period duplex/collision level for one port
  function automatic logic dupcol_level(input int idx, input logic strap, input logic link,
                                        input logic full, input logic coll);
    if (col_split && idx == 0) begin
      dupcol_level = col_ten_flag ? (strap ^ blink_fast) : strap;
    end else if (col_split && idx == 1) begin
      dupcol_level = col_hundred_flag ? (strap ^ blink_fast) : strap;
    end else if (duplex_only) begin
      dupcol_level = (link && full) ? ~strap : strap;
    end else if (!link) begin
      dupcol_level = strap;
    end else if (coll) begin
      dupcol_level = strap ^ blink_slow;
    end else begin
      dupcol_level = full ? ~strap : strap;
    end
  endfunction

  // led drive per phase; dupcol pins stay released until the strap is caught
  always_comb begin
    lnk_nxt = lnk_r;
    spd_nxt = spd_r;
    dc_nxt = dc_r;
    dc_oe_nxt = {NUM_PORTS{phase_r != led_pkg::ST_STRAP}};
    for (int i = 0; i < NUM_PORTS; i++) begin
      case (phase_r)
        led_pkg::ST_STRAP, led_pkg::ST_WAIT: begin
          lnk_nxt[i] = !dual_mode;
          spd_nxt[i] = !dual_mode;
          dc_nxt[i] = strap_r[i];
        end
        led_pkg::ST_ON_TEST: begin
          lnk_nxt[i] = 1'b0;
          spd_nxt[i] = dual_mode;
          dc_nxt[i] = ~strap_r[i];
        end
        led_pkg::ST_YELLOW_TEST: begin
          lnk_nxt[i] = 1'b1;
          spd_nxt[i] = 1'b0;
          dc_nxt[i] = ~strap_r[i];
        end
        led_pkg::ST_OFF_TEST: begin
          lnk_nxt[i] = !dual_mode;
          spd_nxt[i] = !dual_mode;
          dc_nxt[i] = strap_r[i];
        end
        led_pkg::ST_NORMAL: begin
          dc_nxt[i] = dupcol_level(i, strap_r[i], port_link[i], port_full_duplex[i],
                                   port_collision[i]);
          if (!dual_mode) begin
            lnk_nxt[i] = !port_link[i] ? 1'b1 : (port_activity[i] & blink_slow);
            spd_nxt[i] = !(port_link[i] && port_speed_100[i]);
          end else if (!port_link[i]) begin
            lnk_nxt[i] = 1'b0;
            spd_nxt[i] = 1'b0;
          end else if (port_speed_100[i]) begin
            // green blink alternates the steady pair with its swapped state
            lnk_nxt[i] = port_activity[i] & blink_slow;
            spd_nxt[i] = ~(port_activity[i] & blink_slow);
          end else begin
            lnk_nxt[i] = port_activity[i] ? blink_slow : 1'b1;
            spd_nxt[i] = 1'b0;
          end
        end
        default: begin
          lnk_nxt[i] = 1'b1;
          spd_nxt[i] = 1'b1;
          dc_nxt[i] = strap_r[i];
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lnk_r <= '1;
      spd_r <= '1;
      dc_r <= '0;
      dc_oe_r <= '0;
    end else if (ce) begin
      lnk_r <= lnk_nxt;
      spd_r <= spd_nxt;
      dc_r <= dc_nxt;
      dc_oe_r <= dc_oe_nxt;
    end
  end

  // dual on-test for dupcol is the green plus yellow phases together: 2.56 s
  assign link_activity_led = lnk_r;
  assign speed_led = spd_r;
  assign dupcol_out = dc_r;
  assign dupcol_oe = dc_oe_r;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

endmodule
`default_nettype wire

// file: verification/led_bank.sv
// led bank model: discrete leds plus strap resistors on the duplex/collision pins
// assumes the driver's enables; a released pin settles to its strap level
`timescale 1ns/10ps
`default_nettype none
module led_bank #(
  parameter int NUM_PORTS = 5
) (
  input wire logic [NUM_PORTS-1:0] dupcol_out,
  input wire logic [NUM_PORTS-1:0] dupcol_oe,
  input wire logic [NUM_PORTS-1:0] strap_level,
  output logic [NUM_PORTS-1:0] dupcol_in
);
  // resistor level, not the last drive, so a late strap read shows up
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      dupcol_in[i] = dupcol_oe[i] ? dupcol_out[i] : strap_level[i];
    end
  end
endmodule
`default_nettype wire

// file: verification/led_chk.sv
// port checker for the led driver
// assumes bind to port_led_display_driver; normal checks wait out the longest self-test
`timescale 1ns/10ps
`default_nettype none
module led_chk #(
  parameter int NUM_PORTS = 5,
  parameter int TICK_CYCLES = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic strap_input_pin,
  input wire logic hold_test_strap,
  input wire logic [NUM_PORTS-1:0] port_link,
  input wire logic [NUM_PORTS-1:0] port_speed_100,
  input wire logic [NUM_PORTS-1:0] port_full_duplex,
  input wire logic [NUM_PORTS-1:0] port_activity,
  input wire logic [NUM_PORTS-1:0] port_collision,
  input wire logic [NUM_PORTS-1:0] link_activity_led,
  input wire logic [NUM_PORTS-1:0] speed_led,
  input wire logic [NUM_PORTS-1:0] dupcol_in,
  input wire logic [NUM_PORTS-1:0] dupcol_out,
  input wire logic [NUM_PORTS-1:0] dupcol_oe
);
  // margin of a few ticks past the dual test, since the on-test may end a tick early
  localparam int LIM = 612 * TICK_CYCLES;
  int cyc_r;
  logic [NUM_PORTS-1:0] strap_r;
  logic dual_r;
  logic hold_r;
  logic norm;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_r <= 0;
      strap_r <= '0;
      dual_r <= 1'b0;
      hold_r <= 1'b0;
    end else if (!dupcol_oe[0]) begin
      cyc_r <= 0;
      strap_r <= dupcol_in;
      dual_r <= strap_input_pin;
      hold_r <= hold_test_strap;
    end else if (ce && cyc_r < LIM) begin
      cyc_r <= cyc_r + 1;
    end
  end
  assign norm = cyc_r == LIM && !hold_r;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_setup_ready: assert property (psel && !penable && ce |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_bad_addr: assert property (pready && paddr != 8'h00 && paddr != 8'h04 |-> pslverr)
    else $error("unmapped access without error");
  a_on_start: assert property ($rose(dupcol_oe[0]) && !hold_r |-> ##[1:6]
    (link_activity_led == '0 && dupcol_out == ~strap_r))
    else $error("on-test missing after strap");
  a_down_dupcol: assert property (norm && !port_link[2] |=> dupcol_out[2] == strap_r[2])
    else $error("down port duplex led not strap level");
  a_full_dupcol: assert property (norm && port_link[2] && port_full_duplex[2]
    && !port_collision[2] |=> dupcol_out[2] != strap_r[2])
    else $error("full duplex led not lit");
  a_speed_level: assert property (norm && !dual_r |=>
    speed_led[1] == !($past(port_link[1]) && $past(port_speed_100[1])))
    else $error("speed led wrong");
  a_link_idle: assert property (norm && !dual_r && !port_activity[3] |=>
    link_activity_led[3] == !$past(port_link[3]))
    else $error("idle link led wrong");
  a_dual_down: assert property (norm && dual_r && !port_link[0] |=>
    link_activity_led[0] == speed_led[0])
    else $error("dual pair lit on down port");
endmodule
bind port_led_display_driver led_chk #(.NUM_PORTS(NUM_PORTS), .TICK_CYCLES(TICK_CYCLES))
  led_chk_i (
  .pclk, .presetn, .ce, .psel, .penable, .paddr, .pready, .pslverr, .strap_input_pin,
  .hold_test_strap, .port_link, .port_speed_100, .port_full_duplex, .port_activity,
  .port_collision, .link_activity_led, .speed_led, .dupcol_in, .dupcol_out, .dupcol_oe);
`default_nettype wire

// file: verification/testbench.sv
// self-checking bench for the led driver with a short prescaler tick
// assumes led_bank on the duplex/collision pins; 10 Hz blink half period is 40 cycles, 20 Hz blink half period is 20
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er;
  logic strap_input_pin, hold_test_strap;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] port_link, port_speed_100, port_full_duplex, port_activity, port_collision;
  logic [4:0] link_activity_led, speed_led, dupcol_in, dupcol_out, dupcol_oe, pull;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  port_led_display_driver #(.NUM_PORTS(5), .TICK_CYCLES(4)) port_led_display_driver_i (
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .strap_input_pin, .hold_test_strap, .port_link, .port_speed_100,
    .port_full_duplex, .port_activity, .port_collision, .link_activity_led, .speed_led,
    .dupcol_in, .dupcol_out, .dupcol_oe);
  led_bank #(.NUM_PORTS(5)) led_bank_i (.dupcol_out, .dupcol_oe, .strap_level(pull), .dupcol_in);
  task automatic wrap_up();
    if (err_total == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic clk(input int n);
    repeat (n) @(posedge pclk);
  endtask
  function automatic logic pick(input int s, input int b);
    return s == 0 ? link_activity_led[b] : s == 1 ? speed_led[b] : dupcol_out[b];
  endfunction
  // 200 cycles hold exactly five 10 Hz edges, as the tick divides evenly
  task automatic blink(input int s, input int b, input int e);
    logic p;
    int n;
    n = 0;
    p = pick(s, b);
    repeat (200) begin
      @(posedge pclk);
      n += int'(pick(s, b) != p);
      p = pick(s, b);
    end
    chk(32'(n), 32'(e));
  endtask
  // no local wait limit: a slave that never answers runs into the cycle ceiling
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic ports(input logic [4:0] l, s, f, a, c);
    port_link <= l;
    port_speed_100 <= s;
    port_full_duplex <= f;
    port_activity <= a;
    port_collision <= c;
  endtask
  task automatic boot(input logic [4:0] p, input logic dual, input logic hold);
    presetn <= 1'b0;
    pull <= p;
    strap_input_pin <= dual;
    hold_test_strap <= hold;
    ports(5'h00, 5'h00, 5'h00, 5'h00, 5'h00);
    clk(5);
    chk(32'(dupcol_oe), 32'h00);
    presetn <= 1'b1;
    repeat (20) if (dupcol_oe !== 5'h1F) @(posedge pclk);
    chk(32'(dupcol_oe), 32'h1F);
  endtask
  task automatic t_single();
    boot(5'h0A, 1'b0, 1'b0);
    ports(5'h1E, 5'h0C, 5'h14, 5'h04, 5'h08);
    clk(8);
    chk({link_activity_led, speed_led, dupcol_out}, {5'h00, 5'h00, 5'h15});
    clk(992);
    chk({link_activity_led, speed_led, dupcol_out}, {5'h00, 5'h00, 5'h15});
    clk(60);
    chk({link_activity_led, speed_led, dupcol_out}, {5'h1F, 5'h1F, 5'h0A});
    clk(410);
    chk({link_activity_led & 5'h1B, speed_led, dupcol_out & 5'h17}, 15'h0676);
    blink(0, 2, 5);
    blink(2, 3, 5);
    apb(1'b1, 8'h00, 32'h4);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h4);
    blink(2, 3, 0);
    chk(32'(dupcol_out[3]), 32'h1);
    apb(1'b1, 8'h00, 32'h8);
    ports(5'h1E, 5'h0C, 5'h14, 5'h00, 5'h0A);
    blink(2, 0, 10);
    blink(2, 1, 10);
    ports(5'h1A, 5'h0C, 5'h14, 5'h00, 5'h10);
    clk(2);
    blink(2, 0, 0);
    chk(32'(dupcol_out[0]), 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd & 32'h3FF, 32'h145);
  endtask
  task automatic t_dual();
    boot(5'h15, 1'b1, 1'b0);
    ports(5'h1E, 5'h06, 5'h04, 5'h0C, 5'h00);
    clk(8);
    chk({link_activity_led, speed_led, dupcol_out}, {5'h00, 5'h1F, 5'h0A});
    clk(1052);
    chk({link_activity_led, speed_led, dupcol_out}, {5'h1F, 5'h00, 5'h0A});
    clk(1040);
    chk({link_activity_led, speed_led, dupcol_out}, {5'h00, 5'h00, 5'h15});
    clk(400);
    chk({link_activity_led & 5'h13, speed_led & 5'h1B}, 10'h202);
    blink(0, 3, 5);
    blink(1, 2, 5);
    // clock enable low must freeze the prescaler and the leds together
    ce <= 1'b0;
    blink(0, 3, 0);
    ce <= 1'b1;
    blink(0, 3, 5);
  endtask
  task automatic t_hold();
    boot(5'h00, 1'b0, 1'b1);
    clk(50);
    chk({link_activity_led, speed_led}, 10'h3FF);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b1, 8'h00, 32'h3);
    clk(8);
    chk({link_activity_led, speed_led}, 10'h01F);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd & 32'h18, 32'h18);
  endtask
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, strap_input_pin, hold_test_strap} = 6'h00;
    ce = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    pull = 5'h00;
    {port_link, port_speed_100, port_full_duplex, port_activity, port_collision} = 25'h0;
    @(posedge pclk);
    t_single();
    t_dual();
    t_hold();
    wrap_up();
  end
endmodule
`default_nettype wire
